// >>> auto_serial_buffer_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
`include "seq_cfg.svh"

module auto_serial_buffer_sequencer
  import seq_pkg::*;
#(
  parameter logic [12:0] INTERVAL_UNIT = `INTERVAL_UNIT
) (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire reg_req_t   bus,
  output var  logic [7:0] rdata,
  input  wire logic       halt,
  input  wire logic       serial_clock_pin,
  output var  link_pins_t link,
  output var  logic       transfer_irq
);

  logic [2:0]  sck_sync;
  logic        sck_filt;
  logic        next_sck_filt;
  logic        sck_rise;
  logic        sck_fall;

  logic [7:0]  serial_mode_reg;
  logic [7:0]  byte_interval_reg;
  logic [5:0]  buffer_pointer;
  logic [5:0]  reload_ptr;
  logic [7:0]  shift_shadow;
  logic        receive_select;
  logic        repeat_reload_select;
  logic        transfer_active_bit;
  logic        transfer_irq_flag;
  logic        suspended;
  logic [12:0] gap_cnt;
  seq_state_t  state;

  logic [7:0]  next_mode;
  logic [7:0]  next_intv;
  logic [5:0]  next_ptr;
  logic [5:0]  next_reload;
  logic [7:0]  next_shadow;
  logic        next_recv;
  logic        next_reload_sel;
  logic        next_active;
  logic        next_flag;
  logic        next_suspended;
  logic [12:0] next_gap_cnt;
  seq_state_t  next_state;
  logic [7:0]  next_rdata;
  link_pins_t  next_link;
  logic        next_irq;

  logic        serial_if_enable;
  logic        trig;
  logic        set_irq;
  logic        wr_hit;
  logic [12:0] gap_len;
  logic        mem_we;
  logic        mem_re;
  logic [5:0]  mem_addr;
  logic [7:0]  mem_q;
  logic        sh_load;
  logic        sh_so;
  logic        sh_done;

  // serial clock comes from the far side; three stages, edge only once stable
  always_comb begin
    next_sck_filt = (sck_sync[2] == sck_sync[1]) ? sck_sync[2] : sck_filt;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sck_sync <= 3'h0;
      sck_filt <= 1'b0;
    end else begin
      sck_sync <= {sck_sync[1:0], serial_clock_pin};
      sck_filt <= next_sck_filt;
    end
  end

  assign sck_rise = next_sck_filt && !sck_filt;
  assign sck_fall = !next_sck_filt && sck_filt;

  assign serial_if_enable = serial_mode_reg[`MODE_ENABLE_BIT];
  assign wr_hit = bus.wr && (bus.addr < `RAM_BASE);
  // receive mode is outside this block, so only the two transmit modes start
  assign trig = bus.wr && (bus.addr == `REG_SHIFT) && serial_if_enable
             && serial_mode_reg[`MODE_AUTO_BIT] && !receive_select
             && !transfer_active_bit && !halt;
  assign gap_len = byte_interval_reg[`INTV_USE_BIT]
                 ? 13'((13'(byte_interval_reg[4:0]) + 13'h0001) * INTERVAL_UNIT + `INTERVAL_BASE)
                 : `GAP_MIN;

  // software writes win the RAM port; the sequencer waits, stretching the gap
  assign mem_we   = bus.wr && (bus.addr >= `RAM_BASE);
  assign mem_re   = (state == ST_FETCH) && !mem_we && serial_if_enable && !halt;
  assign mem_addr = mem_we ? bus.addr[5:0] : buffer_pointer;
  assign sh_load  = (state == ST_LOAD) && !halt;

  always_comb begin
    next_mode       = serial_mode_reg;
    next_intv       = byte_interval_reg;
    next_ptr        = buffer_pointer;
    next_reload     = reload_ptr;
    next_shadow     = shift_shadow;
    next_recv       = receive_select;
    next_reload_sel = repeat_reload_select;
    next_active     = transfer_active_bit;
    next_suspended  = suspended;
    next_gap_cnt    = gap_cnt;
    next_state      = state;
    set_irq         = 1'b0;
    if (wr_hit) begin
      case (bus.addr)
        `REG_MODE: next_mode = bus.wdata;
        `REG_CTRL: begin
          next_recv       = bus.wdata[`CTRL_RECV_BIT];
          next_reload_sel = bus.wdata[`CTRL_RELOAD_BIT];
        end
        `REG_PTR: begin
          if (!transfer_active_bit) begin
            next_ptr       = bus.wdata[5:0];
            next_suspended = 1'b0;
          end
        end
        `REG_INTV: begin
          if (!transfer_active_bit) begin
            next_intv = bus.wdata;
          end
        end
        default: ;
      endcase
    end
    if (!halt) begin
      case (state)
        ST_IDLE: begin
          if (trig) begin
            next_active    = 1'b1;
            next_suspended = 1'b0;
            next_state     = ST_FETCH;
            if (!suspended) begin
              next_reload = buffer_pointer;
            end
          end
        end
        ST_FETCH: begin
          if (!serial_if_enable) begin
            next_active    = 1'b0;
            next_suspended = 1'b1;
            next_state     = ST_IDLE;
          end else if (mem_re) begin
            next_state = ST_LOAD;
          end
        end
        ST_LOAD: begin
          next_shadow = mem_q;
          next_state  = ST_SHIFT;
        end
        ST_SHIFT: begin
          if (sh_done) begin
            next_gap_cnt = gap_len - 13'h0001;
            next_state   = ST_GAP;
            if (buffer_pointer != 6'h00) begin
              next_ptr = buffer_pointer - 6'h01;
            end else if (repeat_reload_select) begin
              next_ptr = reload_ptr;
            end else begin
              set_irq     = 1'b1;
              next_active = 1'b0;
              next_state  = ST_IDLE;
            end
            if (!serial_if_enable && next_state == ST_GAP) begin
              next_active    = 1'b0;
              next_suspended = 1'b1;
              next_state     = ST_IDLE;
            end
          end
        end
        ST_GAP: begin
          if (!serial_if_enable) begin
            next_active    = 1'b0;
            next_suspended = 1'b1;
            next_state     = ST_IDLE;
          end else if (gap_cnt == 13'h0000) begin
            next_state = ST_FETCH;
          end else begin
            next_gap_cnt = gap_cnt - 13'h0001;
          end
        end
        default: next_state = ST_IDLE;
      endcase
    end
    // a completion in the same cycle as a software clear still sets the flag
    next_flag = set_irq || (transfer_irq_flag
              && !(bus.wr && bus.addr == `REG_FLAG && !bus.wdata[`FLAG_IRQ_BIT]));
    next_irq = set_irq;
    next_link.so        = (transfer_active_bit && next_active) ? sh_so : 1'b0;
    next_link.so_oe     = next_active;
    next_link.sck_claim = next_active;
    next_link.aux_claim = next_active && next_recv;
    next_rdata = 8'h00;
    if (bus.rd) begin
      case (bus.addr)
        `REG_MODE:  next_rdata = serial_mode_reg;
        `REG_CTRL:  next_rdata = {1'b0, receive_select, repeat_reload_select, 1'b0,
                                  transfer_active_bit, 3'h0};
        `REG_PTR:   next_rdata = {2'h0, buffer_pointer};
        `REG_INTV:  next_rdata = byte_interval_reg;
        `REG_SHIFT: next_rdata = shift_shadow;
        `REG_FLAG:  next_rdata = {7'h00, transfer_irq_flag};
        default:    next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      serial_mode_reg      <= `MODE_RESET;
      byte_interval_reg    <= `INTV_RESET;
      buffer_pointer       <= `PTR_RESET;
      reload_ptr           <= `PTR_RESET;
      shift_shadow         <= 8'h00;
      receive_select       <= 1'b0;
      repeat_reload_select <= 1'b0;
      transfer_active_bit  <= 1'b0;
      transfer_irq_flag    <= 1'b0;
      suspended            <= 1'b0;
      gap_cnt              <= 13'h0000;
      state                <= ST_IDLE;
      rdata                <= 8'h00;
      link                 <= '0;
      transfer_irq         <= 1'b0;
    end else begin
      serial_mode_reg      <= next_mode;
      byte_interval_reg    <= next_intv;
      buffer_pointer       <= next_ptr;
      reload_ptr           <= next_reload;
      shift_shadow         <= next_shadow;
      receive_select       <= next_recv;
      repeat_reload_select <= next_reload_sel;
      transfer_active_bit  <= next_active;
      transfer_irq_flag    <= next_flag;
      suspended            <= next_suspended;
      gap_cnt              <= next_gap_cnt;
      state                <= next_state;
      rdata                <= next_rdata;
      link                 <= next_link;
      transfer_irq         <= next_irq;
    end
  end

  byte_buffer_ram u_ram (
    .clk   (mclk),
    .rst   (rst),
    .we    (mem_we),
    .re    (mem_re),
    .addr  (mem_addr),
    .wdata (bus.wdata),
    .q     (mem_q)
  );

  serial_byte_shifter u_shift (
    .clk  (mclk),
    .rst  (rst),
    .rise (sck_rise),
    .fall (sck_fall),
    .hold (halt),
    .load (sh_load),
    .data (mem_q),
    .so   (sh_so),
    .busy (),
    .done (sh_done)
  );

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  so_low_idle_a: assert property (!transfer_active_bit |=> !link.so)
    else $error("serial output not low while idle");
  trig_starts_a: assert property (trig |=> transfer_active_bit && state == ST_FETCH)
    else $error("trigger did not start a fetch");
  trig_fetch_load_a: assert property (mem_re |=> state == ST_LOAD ##1 (state == ST_SHIFT || $past(halt)))
    else $error("fetched byte not loaded into shifter");
  ptr_decrement_a: assert property (sh_done && !halt && buffer_pointer != 6'h00
      |=> buffer_pointer == $past(buffer_pointer) - 6'h01)
    else $error("pointer did not decrement after a byte");
  last_byte_flag_a: assert property (sh_done && !halt && buffer_pointer == 6'h00 && !repeat_reload_select
      |=> transfer_irq_flag && transfer_irq && !transfer_active_bit)
    else $error("final byte did not flag completion");
  repeat_reload_a: assert property (sh_done && !halt && buffer_pointer == 6'h00 && repeat_reload_select
      |=> buffer_pointer == $past(reload_ptr) && !transfer_irq)
    else $error("repeat mode did not reload the pointer");
  suspend_after_byte_a: assert property (sh_done && !halt && !serial_if_enable
      |=> !transfer_active_bit && state == ST_IDLE)
    else $error("suspension did not clear active");
  byte_kept_a: assert property (state == ST_SHIFT && !sh_done |=> transfer_active_bit)
    else $error("byte abandoned before its end");
  halt_freeze_a: assert property (halt |=> $stable(buffer_pointer) && $stable(state))
    else $error("sequencer moved during halt");
  gap_min_a: assert property ($rose(state == ST_GAP) && serial_if_enable && !halt
      |=> state == ST_GAP)
    else $error("byte interval too short");

  basic_done_c: cover property (set_irq);
  repeat_wrap_c: cover property (sh_done && buffer_pointer == 6'h00 && repeat_reload_select);
  suspend_c: cover property ($fell(transfer_active_bit) && suspended);
  resume_c: cover property (trig && suspended);

endmodule
`default_nettype wire

// >>> byte_buffer_ram.sv
`timescale 1ns/10ps
`default_nettype none

// single port: a write wins the cycle, a read answers one cycle later
module byte_buffer_ram (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       we,
  input  wire logic       re,
  input  wire logic [5:0] addr,
  input  wire logic [7:0] wdata,
  output var  logic [7:0] q
);

  logic [7:0] mem [64];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= 8'h00;
    end else if (re && !we) begin
      q <= mem[addr];
    end
  end

endmodule
`default_nettype wire

// >>> seq_cfg.svh
`ifndef SEQ_CFG_SVH
`define SEQ_CFG_SVH

// register offsets on the plain register port
`define REG_MODE        8'h00
`define REG_CTRL        8'h01
`define REG_PTR         8'h02
`define REG_INTV        8'h03
`define REG_SHIFT       8'h04
`define REG_FLAG        8'h05
`define RAM_BASE        8'hc0

// field positions
`define MODE_ENABLE_BIT 7
`define MODE_AUTO_BIT   5
`define CTRL_RECV_BIT   6
`define CTRL_RELOAD_BIT 5
`define CTRL_ACTIVE_BIT 3
`define INTV_USE_BIT    7
`define FLAG_IRQ_BIT    0

// reset values
`define MODE_RESET      8'h00
`define INTV_RESET      8'h00
`define PTR_RESET       6'h00

// timing counts in mclk cycles; LAST_BIT is the bit index that ends a byte
`define INTERVAL_BASE   13'h0038
`define INTERVAL_UNIT   13'h0080
`define GAP_MIN         13'h0002
`define LAST_BIT        3'h7

`endif

// >>> seq_pkg.sv
`default_nettype none

package seq_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FETCH,
    ST_LOAD,
    ST_SHIFT,
    ST_GAP
  } seq_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef struct packed {
    logic so;
    logic so_oe;
    logic sck_claim;
    logic aux_claim;
  } link_pins_t;

endpackage
`default_nettype wire

// >>> serial_byte_shifter.sv
`timescale 1ns/10ps
`default_nettype none
`include "seq_cfg.svh"

// msb first, next bit presented on the falling clock edge
module serial_byte_shifter (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       rise,
  input  wire logic       fall,
  input  wire logic       hold,
  input  wire logic       load,
  input  wire logic [7:0] data,
  output var  logic       so,
  output var  logic       busy,
  output var  logic       done
);

  logic [7:0] sreg;
  logic [7:0] next_sreg;
  logic [2:0] cnt;
  logic [2:0] next_cnt;
  logic       risen;
  logic       next_risen;
  logic       next_busy;
  logic       next_done;

  always_comb begin
    next_sreg  = sreg;
    next_cnt   = cnt;
    next_risen = risen;
    next_busy  = busy;
    // a done that meets a halt waits for the sequencer instead of being lost
    next_done  = hold ? done : 1'b0;
    if (load) begin
      next_sreg  = data;
      next_cnt   = 3'h0;
      next_risen = 1'b0;
      next_busy  = 1'b1;
    end else if (busy && !hold) begin
      // halt freezes the byte mid-way; edges during halt are lost
      if (rise) begin
        next_risen = 1'b1;
        if (cnt == `LAST_BIT) begin
          next_busy = 1'b0;
          next_done = 1'b1;
        end else begin
          next_cnt = cnt + 3'h1;
        end
      end else if (fall && risen) begin
        next_sreg  = {sreg[6:0], 1'b0};
        next_risen = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sreg  <= 8'h00;
      cnt   <= 3'h0;
      risen <= 1'b0;
      busy  <= 1'b0;
      done  <= 1'b0;
    end else begin
      sreg  <= next_sreg;
      cnt   <= next_cnt;
      risen <= next_risen;
      busy  <= next_busy;
      done  <= next_done;
    end
  end

  assign so = sreg[7];

endmodule
`default_nettype wire

// >>> serial_slave_model.sv
`timescale 1ns/10ps
`default_nettype none

// far-side slave: makes the link clock only while the block claims the pins
module serial_slave_model #(
  parameter int GAP_NS = 1000
) (
  input  wire logic link_claim,
  input  wire logic so,
  input  wire logic hold,
  output var  logic sck,
  output var  logic in_byte
);
  logic [7:0] got [$];
  logic [7:0] sr;

  initial begin
    sck     = 1'b0;
    in_byte = 1'b0;
    sr      = 8'h00;
    forever begin
      wait (link_claim === 1'b1);
      // room for the pointer step and buffer fetch between bytes
      #(GAP_NS);
      if (link_claim === 1'b1) begin
        in_byte = 1'b1;
        for (int i = 0; i < 8; i++) begin
          // pause only between pulses, so no edge falls into a halt
          wait (hold === 1'b0);
          sck = 1'b1;
          sr  = {sr[6:0], so};
          // the byte counts at its eighth rise, when the block already ends it
          if (i == 7) begin
            got.push_back(sr);
            in_byte = 1'b0;
          end
          #62.5;
          sck = 1'b0;
          #62.5;
        end
      end
    end
  end
endmodule

`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "seq_cfg.svh"

module tb_top
  import seq_pkg::*;
;
  logic       mclk;
  logic       rst;
  reg_req_t   bus;
  logic [7:0] rdata;
  logic       halt;
  logic       sck;
  logic       slave_hold;
  logic       in_byte;
  link_pins_t link;
  logic       transfer_irq;
  int         n_fail;
  int         n_checks;
  int         n_irq;
  int         n_bad_pin;
  int         irq_base;
  logic [7:0] v;

  auto_serial_buffer_sequencer #(.INTERVAL_UNIT(13'h0004)) u_auto_serial_buffer_sequencer (
    .mclk             (mclk),
    .rst              (rst),
    .bus              (bus),
    .rdata            (rdata),
    .halt             (halt),
    .serial_clock_pin (sck),
    .link             (link),
    .transfer_irq     (transfer_irq)
  );

  serial_slave_model u_serial_slave_model (
    .link_claim (link.sck_claim),
    .so         (link.so),
    .hold       (slave_hold),
    .sck        (sck),
    .in_byte    (in_byte)
  );

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    if (rst) begin
      n_irq     <= 0;
      n_bad_pin <= 0;
    end else begin
      if (transfer_irq === 1'b1) n_irq <= n_irq + 1;
      if (link.aux_claim !== 1'b0 || link.so_oe !== link.sck_claim
          || (link.sck_claim === 1'b0 && link.so !== 1'b0))
        n_bad_pin <= n_bad_pin + 1;
    end
  end

  function automatic logic [7:0] pat(input int i);
    return 8'h3c ^ 8'(i * 37);
  endfunction

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic give_up(input string what);
    n_fail++;
    $display("MISMATCH %0t timeout: %s", $time, what);
    summarize();
  endtask

  task automatic chk(input logic [7:0] act, input logic [7:0] exp, input string what);
    n_checks++;
    if (act !== exp) begin
      n_fail++;
      $display("MISMATCH %0t %s: got %h want %h", $time, what, act, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b0};
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
    #1 d = rdata;
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 4000; i++) begin
      rd(`REG_CTRL, v);
      if (v[`CTRL_ACTIVE_BIT] === 1'b0) return;
    end
    give_up("active bit");
  endtask

  task automatic wait_bytes(input int n, input logic mid);
    for (int i = 0; i < 20000; i++) begin
      @(posedge mclk);
      if (u_serial_slave_model.got.size() >= n && (!mid || in_byte === 1'b1)) return;
    end
    give_up("slave bytes");
  endtask

  // expects got[k] to walk the buffer from index len-1 down to 0, wrapping
  task automatic chk_seq(input int n, input int len);
    chk(8'(u_serial_slave_model.got.size()), 8'(n), "byte count");
    for (int k = 0; k < n && k < u_serial_slave_model.got.size(); k++)
      chk(u_serial_slave_model.got[k], pat(len - 1 - k % len), "byte value");
  endtask

  task automatic start(input logic [7:0] ctrl, input int n);
    for (int i = 0; i < n; i++) wr(`RAM_BASE + 8'(i), pat(i));
    wr(`REG_MODE, 8'ha0);
    wr(`REG_CTRL, ctrl);
    wr(`REG_PTR, 8'(n - 1));
    u_serial_slave_model.got.delete();
    irq_base = n_irq;
    wr(`REG_SHIFT, 8'hff);
  endtask

  task automatic t_reset();
    logic [7:0] a [7] = '{`REG_MODE, `REG_CTRL, `REG_PTR, `REG_INTV, `REG_FLAG, 8'h10, `RAM_BASE};
    for (int i = 0; i < 7; i++) begin
      rd(a[i], v);
      chk(v, 8'h00, "reset value");
    end
    chk({7'h00, link.so}, 8'h00, "idle data line");
    $display("test reset done");
  endtask

  task automatic t_basic();
    start(8'h00, 3);
    rd(`REG_CTRL, v);
    chk({7'h00, v[`CTRL_ACTIVE_BIT]}, 8'h01, "active after trigger");
    wr(`REG_PTR, 8'h07);
    wait_idle();
    chk_seq(3, 3);
    chk(8'(n_irq - irq_base), 8'h01, "completion pulse");
    rd(`REG_SHIFT, v);
    chk(v, pat(0), "shift holds last buffer byte");
    rd(`REG_FLAG, v);
    chk(v, 8'h01, "flag set");
    rd(`REG_PTR, v);
    chk(v, 8'h00, "pointer at end");
    wr(`REG_FLAG, 8'h00);
    rd(`REG_FLAG, v);
    chk(v, 8'h00, "flag cleared");
    $display("test basic done");
  endtask

  task automatic t_repeat();
    start(8'h20, 2);
    wait_bytes(5, 1'b0);
    wr(`REG_MODE, 8'h20);
    wait_idle();
    chk(8'(u_serial_slave_model.got.size() >= 5), 8'h01, "repeat ran on");
    chk_seq(u_serial_slave_model.got.size(), 2);
    chk(8'(n_irq - irq_base), 8'h00, "no pulse in repeat");
    $display("test repeat done");
  endtask

  task automatic t_suspend();
    start(8'h00, 4);
    wait_bytes(1, 1'b1);
    wr(`REG_MODE, 8'h20);
    wait_idle();
    chk(8'(u_serial_slave_model.got.size()), 8'h02, "byte finished");
    chk({7'h00, link.sck_claim}, 8'h00, "pins released");
    rd(`REG_PTR, v);
    chk(v, 8'h01, "pointer kept");
    chk(8'(n_irq - irq_base), 8'h00, "no pulse on suspend");
    wr(`REG_MODE, 8'ha0);
    wr(`REG_SHIFT, 8'h00);
    wait_idle();
    chk_seq(4, 4);
    chk(8'(n_irq - irq_base), 8'h01, "pulse after resume");
    wr(`REG_FLAG, 8'h00);
    $display("test suspend done");
  endtask

  task automatic t_halt();
    wr(`REG_INTV, 8'h80);
    start(8'h00, 2);
    wait_bytes(0, 1'b1);
    repeat (30) @(posedge mclk);
    slave_hold <= 1'b1;
    repeat (30) @(posedge mclk);
    halt <= 1'b1;
    repeat (50) @(posedge mclk);
    chk({7'h00, link.sck_claim}, 8'h01, "held during halt");
    halt <= 1'b0;
    repeat (10) @(posedge mclk);
    slave_hold <= 1'b0;
    wait_idle();
    chk_seq(2, 2);
    chk(8'(n_irq - irq_base), 8'h01, "pulse after halt");
    rd(`REG_INTV, v);
    chk(v, 8'h80, "interval kept");
    wr(`REG_FLAG, 8'h00);
    $display("test halt done");
  endtask

  task automatic t_refuse();
    wr(`REG_CTRL, 8'h40);
    wr(`REG_MODE, 8'ha0);
    wr(`REG_SHIFT, 8'hff);
    rd(`REG_CTRL, v);
    chk({7'h00, v[`CTRL_ACTIVE_BIT]}, 8'h00, "receive select blocks");
    wr(`REG_CTRL, 8'h00);
    wr(`REG_MODE, 8'h80);
    wr(`REG_SHIFT, 8'hff);
    rd(`REG_CTRL, v);
    chk({7'h00, v[`CTRL_ACTIVE_BIT]}, 8'h00, "auto select needed");
    chk(8'(n_bad_pin), 8'h00, "pin ownership and idle level");
    $display("test refuse done");
  endtask

  initial begin
    rst        = 1'b1;
    halt       = 1'b0;
    slave_hold = 1'b0;
    bus        = '{addr: 8'h00, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
    n_fail     = 0;
    n_checks   = 0;
    irq_base   = 0;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_basic();
    t_repeat();
    t_suspend();
    t_halt();
    t_refuse();
    summarize();
  end
endmodule

`default_nettype wire
